// [rtl/lbr_pkg.sv]
// constants for the lcd bias rail configuration register bank
package lbr_pkg;
	// register offsets
	localparam logic [7:0] OFS_LOGIC_LDO_CTRL = 8'h0b;
	localparam logic [7:0] OFS_LOGIC_LDO_VOLT_BOOST_OUT = 8'h0c;
	localparam logic [7:0] OFS_POSITIVE_RAIL_TARGET = 8'h0d;
	localparam logic [7:0] OFS_NEGATIVE_RAIL_TARGET = 8'h0e;
	localparam logic [7:0] OFS_REFERENCE_RAIL_TARGET = 8'h0f;
	localparam logic [7:0] OFS_POSITIVE_RAIL_SEQUENCE = 8'h10;
	localparam logic [7:0] OFS_NEGATIVE_RAIL_SEQUENCE = 8'h11;
	// field positions
	localparam int LOGIC_EN_BIT = 0;
	localparam int LOGIC_SD_LSB = 1;
	localparam int LOGIC_SU_LSB = 4;
	localparam int LOGIC_VOUT_LSB = 6;
	localparam int BOOST_CODE_LSB = 0;
	localparam int SEQ_SD_LSB = 0;
	localparam int SEQ_SU_LSB = 4;
	// masks of implemented bits, the rest read as zero
	localparam logic [7:0] MASK_CTRL = 8'h7f;
	localparam logic [7:0] MASK_TARGET = 8'h3f;
	// reset values
	localparam logic [7:0] RST_LOGIC_LDO_CTRL = 8'h00;
	localparam logic [7:0] RST_LOGIC_LDO_VOLT_BOOST_OUT = 8'h00;
	localparam logic [7:0] RST_POSITIVE_RAIL_TARGET = 8'h00;
	localparam logic [7:0] RST_NEGATIVE_RAIL_TARGET = 8'h00;
	localparam logic [7:0] RST_REFERENCE_RAIL_TARGET = 8'h00;
	localparam logic [7:0] RST_POSITIVE_RAIL_SEQUENCE = 8'h00;
	localparam logic [7:0] RST_NEGATIVE_RAIL_SEQUENCE = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	// voltage decode, millivolts
	localparam logic [15:0] BOOST_BASE_MV = 16'h1194;
	localparam logic [15:0] BIAS_BASE_MV = 16'h0fa0;
	localparam logic [15:0] CODE_STEP_MV = 16'h0032;
	localparam logic [5:0] BIAS_CLAMP_CODE = 6'h28;
	localparam logic [15:0] LOGIC_BASE_MV = 16'h0708;
	localparam logic [15:0] LOGIC_STEP_MV = 16'h01f4;

	// logic-supply delay code to milliseconds
	function automatic logic [7:0] lbr_logic_delay_ms(input logic [2:0] code);
		logic [7:0] ms;
		ms = 8'h00;
		unique case (code)
			3'h0: ms = 8'h00;
			3'h1: ms = 8'h02;
			3'h2: ms = 8'h05;
			3'h3: ms = 8'h0a;
			3'h4: ms = 8'h14;
			3'h5: ms = 8'h32;
			3'h6: ms = 8'h64;
			3'h7: ms = 8'hc8;
		endcase
		return ms;
	endfunction : lbr_logic_delay_ms
endpackage : lbr_pkg

// [rtl/lbr_rail_seq.sv]
// start-up and shutdown delay sequencer for one rail
`timescale 1ns/1ns
module lbr_rail_seq #(
	parameter int CYC_PER_MS = 100000
) (
	input wire logic i_mclk, // system clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic i_request, // rail wanted on
	input wire logic [7:0] i_startup_ms, // start-up delay, ms
	input wire logic [7:0] i_shutdown_ms, // shutdown delay, ms
	output logic o_on, // rail powered
	output logic o_settled // rail on and start-up delay done
);
	localparam int CW = $clog2(CYC_PER_MS);
	localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);

	generate
		if (CYC_PER_MS < 2) begin : g_bad
			$error("CYC_PER_MS must be at least 2");
		end
	endgenerate

	typedef enum logic [1:0] {RAIL_OFF, RAIL_RAMP_UP, RAIL_ON, RAIL_RAMP_DOWN} lbr_rail_e;
	lbr_rail_e state;
	logic [CW-1:0] cyc;
	logic [7:0] ms_left;

	// own divider restarted per event so delays are exact whole milliseconds
	wire ms_tick = (cyc == CYC_LAST);
	wire ms_done = ms_tick && (ms_left == 8'h01);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= RAIL_OFF;
			cyc <= '0;
			ms_left <= 8'h00;
		end else begin
			cyc <= ms_tick ? '0 : cyc + CW'(1);
			if (ms_tick) begin
				ms_left <= ms_left - 8'h01;
			end
			unique case (state)
				RAIL_OFF: begin
					cyc <= '0;
					ms_left <= i_startup_ms;
					if (i_request) begin
						state <= (i_startup_ms == 8'h00) ? RAIL_ON : RAIL_RAMP_UP;
					end
				end
				RAIL_RAMP_UP: begin
					if (!i_request) begin
						state <= RAIL_OFF;
					end else if (ms_done) begin
						state <= RAIL_ON;
					end
				end
				RAIL_ON: begin
					cyc <= '0;
					ms_left <= i_shutdown_ms;
					if (!i_request) begin
						state <= (i_shutdown_ms == 8'h00) ? RAIL_OFF : RAIL_RAMP_DOWN;
					end
				end
				RAIL_RAMP_DOWN: begin
					if (i_request) begin
						state <= RAIL_ON;
					end else if (ms_done) begin
						state <= RAIL_OFF;
					end
				end
			endcase
		end
	end

	// rail stays powered while its shutdown delay runs
	assign o_on = (state == RAIL_ON) || (state == RAIL_RAMP_DOWN);
	assign o_settled = (state == RAIL_ON);
endmodule : lbr_rail_seq

// [rtl/lbr_regs.sv]
// lcd bias rail configuration registers, decode and rail sequencing
`timescale 1ns/1ns
module lbr_regs #(
	parameter int CYC_PER_MS = lbr_pkg::CYC_PER_MS
) (
	input wire logic i_mclk, // 100 MHz clock
	input wire logic i_rst, // synchronous reset, active high
	input wire logic [7:0] i_reg_addr, // register address from serial decoder
	input wire logic i_reg_wr, // write strobe, one cycle
	input wire logic [7:0] i_reg_wdata, // write data
	input wire logic i_reg_rd, // read strobe, one cycle
	output logic [7:0] o_reg_rdata, // read data, valid cycle after strobe
	input wire logic i_bias_section_enable_pin, // lcd enable pin, asynchronous
	input wire logic i_boost_started, // boost regulator up, asynchronous
	input wire logic i_positive_enable, // positive rail enable bit
	input wire logic i_negative_enable, // negative rail enable bit
	input wire logic i_reference_enable, // reference rail enable bit
	output logic o_boost_enable, // run the bias boost regulator
	output logic o_logic_supply_on, // logic supply regulator enable
	output logic o_positive_on, // positive bias regulator enable
	output logic o_negative_on, // negative bias pump enable
	output logic o_reference_on, // reference regulator enable
	output logic o_backlight_allow, // backlight may be enabled
	output logic [15:0] o_logic_supply_mv, // logic supply target, mV
	output logic [15:0] o_boost_mv, // bias boost target, mV
	output logic [15:0] o_positive_mv, // positive bias target, mV
	output logic [15:0] o_negative_mv, // negative bias magnitude, mV
	output logic [15:0] o_reference_mv // reference target, mV
);
	logic [7:0] logic_ldo_ctrl;
	logic [7:0] logic_ldo_volt_boost_out;
	logic [7:0] positive_rail_target;
	logic [7:0] negative_rail_target;
	logic [7:0] reference_rail_target;
	logic [7:0] positive_rail_sequence;
	logic [7:0] negative_rail_sequence;

	// address decode
	wire sel_ctrl = (i_reg_addr == lbr_pkg::OFS_LOGIC_LDO_CTRL);
	wire sel_vb = (i_reg_addr == lbr_pkg::OFS_LOGIC_LDO_VOLT_BOOST_OUT);
	wire sel_pt = (i_reg_addr == lbr_pkg::OFS_POSITIVE_RAIL_TARGET);
	wire sel_nt = (i_reg_addr == lbr_pkg::OFS_NEGATIVE_RAIL_TARGET);
	wire sel_rt = (i_reg_addr == lbr_pkg::OFS_REFERENCE_RAIL_TARGET);
	wire sel_ps = (i_reg_addr == lbr_pkg::OFS_POSITIVE_RAIL_SEQUENCE);
	wire sel_ns = (i_reg_addr == lbr_pkg::OFS_NEGATIVE_RAIL_SEQUENCE);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			logic_ldo_ctrl <= lbr_pkg::RST_LOGIC_LDO_CTRL;
			logic_ldo_volt_boost_out <= lbr_pkg::RST_LOGIC_LDO_VOLT_BOOST_OUT;
			positive_rail_target <= lbr_pkg::RST_POSITIVE_RAIL_TARGET;
			negative_rail_target <= lbr_pkg::RST_NEGATIVE_RAIL_TARGET;
			reference_rail_target <= lbr_pkg::RST_REFERENCE_RAIL_TARGET;
			positive_rail_sequence <= lbr_pkg::RST_POSITIVE_RAIL_SEQUENCE;
			negative_rail_sequence <= lbr_pkg::RST_NEGATIVE_RAIL_SEQUENCE;
		end else if (i_reg_wr) begin
			if (sel_ctrl) logic_ldo_ctrl <= i_reg_wdata & lbr_pkg::MASK_CTRL;
			if (sel_vb) logic_ldo_volt_boost_out <= i_reg_wdata;
			if (sel_pt) positive_rail_target <= i_reg_wdata & lbr_pkg::MASK_TARGET;
			if (sel_nt) negative_rail_target <= i_reg_wdata & lbr_pkg::MASK_TARGET;
			if (sel_rt) reference_rail_target <= i_reg_wdata & lbr_pkg::MASK_TARGET;
			if (sel_ps) positive_rail_sequence <= i_reg_wdata;
			if (sel_ns) negative_rail_sequence <= i_reg_wdata;
		end
	end

	// unmapped addresses read as zero
	wire [7:0] rd_mux = ({8{sel_ctrl}} & logic_ldo_ctrl)
		| ({8{sel_vb}} & logic_ldo_volt_boost_out)
		| ({8{sel_pt}} & positive_rail_target)
		| ({8{sel_nt}} & negative_rail_target)
		| ({8{sel_rt}} & reference_rail_target)
		| ({8{sel_ps}} & positive_rail_sequence)
		| ({8{sel_ns}} & negative_rail_sequence);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rd_mux;
		end
	end

	// pin synchronisers: three stages, change accepted when stages two and three agree
	logic [1:0] sync_meta;
	logic [1:0] sync_mid;
	logic [1:0] sync_last;
	logic [1:0] sync_filt;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync_meta <= 2'h0;
			sync_mid <= 2'h0;
			sync_last <= 2'h0;
			sync_filt <= 2'h0;
		end else begin
			sync_meta <= {i_boost_started, i_bias_section_enable_pin};
			sync_mid <= sync_meta;
			sync_last <= sync_mid;
			sync_filt <= (sync_mid & sync_last) | (sync_filt & (sync_mid | sync_last));
		end
	end

	wire pin_enable = sync_filt[0];
	// a stale started report is ignored once the pin is low
	wire boost_up = sync_filt[0] & sync_filt[1];

	// field extraction
	wire logic_en = logic_ldo_ctrl[lbr_pkg::LOGIC_EN_BIT];
	wire [2:0] logic_sd_code = logic_ldo_ctrl[lbr_pkg::LOGIC_SD_LSB +: 3];
	wire [2:0] logic_su_code = logic_ldo_ctrl[lbr_pkg::LOGIC_SU_LSB +: 3];
	wire [1:0] logic_vout_code = logic_ldo_volt_boost_out[lbr_pkg::LOGIC_VOUT_LSB +: 2];
	wire [5:0] boost_code = logic_ldo_volt_boost_out[lbr_pkg::BOOST_CODE_LSB +: 6];
	wire [7:0] pos_su_ms = {4'h0, positive_rail_sequence[lbr_pkg::SEQ_SU_LSB +: 4]};
	wire [7:0] pos_sd_ms = {4'h0, positive_rail_sequence[lbr_pkg::SEQ_SD_LSB +: 4]};
	wire [7:0] neg_su_ms = {4'h0, negative_rail_sequence[lbr_pkg::SEQ_SU_LSB +: 4]};
	wire [7:0] neg_sd_ms = {4'h0, negative_rail_sequence[lbr_pkg::SEQ_SD_LSB +: 4]};
	wire [7:0] logic_su_ms = lbr_pkg::lbr_logic_delay_ms(logic_su_code);
	wire [7:0] logic_sd_ms = lbr_pkg::lbr_logic_delay_ms(logic_sd_code);

	// rail requests: bias outputs wait for the boost
	wire pos_req = i_positive_enable & boost_up;
	wire neg_req = i_negative_enable & boost_up;
	wire ref_req = i_reference_enable & boost_up;

	logic logic_on;
	logic logic_settled;
	logic pos_on;
	logic pos_settled;
	logic neg_on;
	logic neg_settled;

	lbr_rail_seq #(.CYC_PER_MS(CYC_PER_MS)) u_logic_seq (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_request(logic_en),
		.i_startup_ms(logic_su_ms),
		.i_shutdown_ms(logic_sd_ms),
		.o_on(logic_on),
		.o_settled(logic_settled)
	);

	lbr_rail_seq #(.CYC_PER_MS(CYC_PER_MS)) u_pos_seq (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_request(pos_req),
		.i_startup_ms(pos_su_ms),
		.i_shutdown_ms(pos_sd_ms),
		.o_on(pos_on),
		.o_settled(pos_settled)
	);

	lbr_rail_seq #(.CYC_PER_MS(CYC_PER_MS)) u_neg_seq (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_request(neg_req),
		.i_startup_ms(neg_su_ms),
		.i_shutdown_ms(neg_sd_ms),
		.o_on(neg_on),
		.o_settled(neg_settled)
	);

	// every enabled output settled before the backlight may start
	wire next_backlight_allow = (~logic_en | logic_settled)
		& (~i_positive_enable | pos_settled)
		& (~i_negative_enable | neg_settled)
		& (~i_reference_enable | ref_req);

	// voltage decode
	wire [5:0] pos_clamped = (positive_rail_target[5:0] > lbr_pkg::BIAS_CLAMP_CODE)
		? lbr_pkg::BIAS_CLAMP_CODE : positive_rail_target[5:0];
	wire [5:0] neg_clamped = (negative_rail_target[5:0] > lbr_pkg::BIAS_CLAMP_CODE)
		? lbr_pkg::BIAS_CLAMP_CODE : negative_rail_target[5:0];
	wire [5:0] ref_clamped = (reference_rail_target[5:0] > lbr_pkg::BIAS_CLAMP_CODE)
		? lbr_pkg::BIAS_CLAMP_CODE : reference_rail_target[5:0];
	wire [15:0] next_boost_mv = lbr_pkg::BOOST_BASE_MV
		+ 16'(boost_code * lbr_pkg::CODE_STEP_MV);
	wire [15:0] next_positive_mv = lbr_pkg::BIAS_BASE_MV
		+ 16'(pos_clamped * lbr_pkg::CODE_STEP_MV);
	wire [15:0] next_negative_mv = lbr_pkg::BIAS_BASE_MV
		+ 16'(neg_clamped * lbr_pkg::CODE_STEP_MV);
	wire [15:0] next_reference_mv = lbr_pkg::BIAS_BASE_MV
		+ 16'(ref_clamped * lbr_pkg::CODE_STEP_MV);
	wire [15:0] next_logic_supply_mv = lbr_pkg::LOGIC_BASE_MV
		+ 16'(logic_vout_code * lbr_pkg::LOGIC_STEP_MV);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_boost_enable <= 1'b0;
			o_logic_supply_on <= 1'b0;
			o_positive_on <= 1'b0;
			o_negative_on <= 1'b0;
			o_reference_on <= 1'b0;
			o_backlight_allow <= 1'b0;
			o_logic_supply_mv <= lbr_pkg::LOGIC_BASE_MV;
			o_boost_mv <= lbr_pkg::BOOST_BASE_MV;
			o_positive_mv <= lbr_pkg::BIAS_BASE_MV;
			o_negative_mv <= lbr_pkg::BIAS_BASE_MV;
			o_reference_mv <= lbr_pkg::BIAS_BASE_MV;
		end else begin
			o_boost_enable <= pin_enable;
			o_logic_supply_on <= logic_on;
			o_positive_on <= pos_on;
			o_negative_on <= neg_on;
			o_reference_on <= ref_req;
			o_backlight_allow <= next_backlight_allow;
			o_logic_supply_mv <= next_logic_supply_mv;
			o_boost_mv <= next_boost_mv;
			o_positive_mv <= next_positive_mv;
			o_negative_mv <= next_negative_mv;
			o_reference_mv <= next_reference_mv;
		end
	end
endmodule : lbr_regs

// [testbench/lbr_regs_assertions.sv]
// port checks for the lcd bias rail register bank
`timescale 1ns/1ns
module lbr_regs_chk (
	input wire logic i_mclk, // clock
	input wire logic i_rst, // sync reset
	input wire logic [7:0] i_reg_addr, // address
	input wire logic i_reg_wr, // write strobe
	input wire logic [7:0] i_reg_wdata, // write data
	input wire logic i_positive_enable, // rail enable
	input wire logic i_negative_enable, // rail enable
	input wire logic i_reference_enable, // rail enable
	input wire logic i_boost_started, // boost report
	input wire logic o_boost_enable, // boost run
	input wire logic o_positive_on, // rail on
	input wire logic o_negative_on, // rail on
	input wire logic o_reference_on, // rail on
	input wire logic o_backlight_allow, // backlight gate
	input wire logic [15:0] o_boost_mv, // target
	input wire logic [15:0] o_positive_mv, // target
	input wire logic [15:0] o_negative_mv, // target
	input wire logic [15:0] o_reference_mv // target
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
	// codes above 40 saturate at the top level
	function automatic logic [15:0] bias_mv(input logic [7:0] c);
		return (c[5:0] > 6'h28) ? 16'h1770 : 16'h0fa0 + 16'h32 * c[5:0];
	endfunction : bias_mv
	sequence s_wr(a);
		i_reg_wr && i_reg_addr == a;
	endsequence
	// no second write to the same place before the decode lands
	sequence s_quiet(a);
		!(i_reg_wr && i_reg_addr == a);
	endsequence
	property p_bias(a, mv);
		s_wr(a) ##1 s_quiet(a) |=> mv == bias_mv($past(i_reg_wdata, 2));
	endproperty
	AST_BOOST_CODE: assert property (s_wr(8'h0c) ##1 s_quiet(8'h0c)
		|=> o_boost_mv == 16'h1194 + 16'h32 * ($past(i_reg_wdata, 2) & 8'h3f))
		else $error("boost target mismatch");
	AST_POS_CODE: assert property (p_bias(8'h0d, o_positive_mv))
		else $error("positive target mismatch");
	AST_NEG_CODE: assert property (p_bias(8'h0e, o_negative_mv))
		else $error("negative target mismatch");
	AST_REF_CODE: assert property (p_bias(8'h0f, o_reference_mv))
		else $error("reference target mismatch");
	AST_BOOST_FIRST: assert property ($rose(o_positive_on || o_negative_on || o_reference_on)
		|-> o_boost_enable) else $error("bias rail up before boost");
	AST_REF_FOLLOW: assert property ($rose(i_reference_enable) && o_boost_enable
		&& i_boost_started && $past(i_boost_started, 4) |=> o_reference_on)
		else $error("reference rail did not follow");
	AST_BL_POS: assert property (o_backlight_allow && $past(i_positive_enable)
		|-> o_positive_on) else $error("backlight allowed before positive rail");
	AST_BL_NEG: assert property (o_backlight_allow && $past(i_negative_enable)
		|-> o_negative_on) else $error("backlight allowed before negative rail");
endmodule : lbr_regs_chk
bind lbr_regs lbr_regs_chk chk (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
	.i_positive_enable, .i_negative_enable, .i_reference_enable, .i_boost_started,
	.o_boost_enable, .o_positive_on, .o_negative_on, .o_reference_on, .o_backlight_allow,
	.o_boost_mv, .o_positive_mv, .o_negative_mv, .o_reference_mv);

// [testbench/lbr_host.sv]
// host model: register port strobes and the lcd enable pin
`timescale 1ns/1ns
module lbr_host (
	input wire logic i_mclk, // clock
	input wire logic [7:0] i_reg_rdata, // read data
	output logic [7:0] o_reg_addr, // address
	output logic o_reg_wr, // write strobe
	output logic [7:0] o_reg_wdata, // write data
	output logic o_reg_rd, // read strobe
	output logic o_pin // lcd enable pin
);
	initial begin
		{o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd, o_pin} = 19'h0;
	end
	// address inverted after each transfer, and data after each write, so stale values never match
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_reg_addr <= a;
		o_reg_wdata <= d;
		o_reg_wr <= 1'b1;
		@(posedge i_mclk);
		o_reg_wr <= 1'b0;
		o_reg_addr <= ~a;
		o_reg_wdata <= ~d;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_reg_addr <= a;
		o_reg_rd <= 1'b1;
		@(posedge i_mclk);
		o_reg_rd <= 1'b0;
		o_reg_addr <= ~a;
		#1;
		d = i_reg_rdata;
	endtask : rd
	task pin(input logic v);
		@(posedge i_mclk);
		o_pin <= v;
	endtask : pin
endmodule : lbr_host

// [testbench/lbr_regs_tb.sv]
// self-checking bench for the lcd bias rail register bank
`timescale 1ns/1ns
module lbr_regs_tb;
	localparam int CPM = 10; // short ms keeps delays to a few hundred cycles
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_boost_started = 1'b0;
	logic i_reference_enable = 1'b0;
	logic [1:0] ena = 2'h0;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d, a;
	logic i_reg_wr, i_reg_rd, i_bias_section_enable_pin, o_boost_enable, o_logic_supply_on;
	logic o_positive_on, o_negative_on, o_reference_on, o_backlight_allow;
	logic [15:0] o_logic_supply_mv, o_boost_mv, o_positive_mv, o_negative_mv, o_reference_mv;
	wire logic [2:0] ons = {o_negative_on, o_positive_on, o_logic_supply_on};
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h28, 8'h29, 8'h3f};
	lbr_regs #(.CYC_PER_MS(CPM)) uut (.i_mclk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
		.i_reg_rd, .o_reg_rdata, .i_bias_section_enable_pin, .i_boost_started,
		.i_positive_enable(ena[0]), .i_negative_enable(ena[1]), .i_reference_enable,
		.o_boost_enable, .o_logic_supply_on, .o_positive_on, .o_negative_on, .o_reference_on,
		.o_backlight_allow, .o_logic_supply_mv, .o_boost_mv, .o_positive_mv, .o_negative_mv,
		.o_reference_mv);
	lbr_host host (.i_mclk, .i_reg_rdata(o_reg_rdata), .o_reg_addr(i_reg_addr),
		.o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd),
		.o_pin(i_bias_section_enable_pin));
	always #5 i_mclk = ~i_mclk;
	function automatic logic [15:0] bias(input logic [7:0] c);
		return (c > 8'h28) ? 16'h1770 : 16'h0fa0 + 16'h32 * c;
	endfunction : bias
	function automatic logic [7:0] mask(input logic [7:0] r);
		case (r)
			8'h0b: return 8'h7f;
			8'h0c, 8'h10, 8'h11: return 8'hff;
			8'h0d, 8'h0e, 8'h0f: return 8'h3f;
			default: return 8'h00;
		endcase
	endfunction : mask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task chkd(input string nm, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			n_fail++;
			$display("FAIL %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chkd
	// edges until rail w reaches v, bounded
	// exact delay plus one edge to take the request and one for the output flop
	task wait_for(input int w, input logic v);
		n = 0;
		while (ons[w] !== v && n < 400) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
	endtask : wait_for
	task rail(input logic [7:0] r, input logic [7:0] s, input int i);
		host.wr(r, s);
		@(posedge i_mclk);
		ena[i] <= 1'b1;
		wait_for(i + 1, 1'b1);
		chkd("rail up", s[7:4] * CPM + 2, n);
		chk("backlight", 16'h1, o_backlight_allow);
		@(posedge i_mclk);
		ena[i] <= 1'b0;
		wait_for(i + 1, 1'b0);
		chkd("rail down", s[3:0] * CPM + 2, n);
	endtask : rail
	task close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		i_boost_started <= 1'b1;
		for (a = 8'h0a; a <= 8'h12; a++) begin
			host.rd(a, d);
			chk("reset value", 16'h0, d);
			host.wr(a, 8'hfe);
			host.rd(a, d);
			chk("readback", mask(a) & 8'hfe, d);
		end
		chk("logic mv", 16'h0ce4, o_logic_supply_mv);
		chk("pos clamp", 16'h1770, o_positive_mv);
		foreach (codes[k]) begin
			for (a = 8'h0c; a <= 8'h0f; a++) host.wr(a, codes[k]);
			repeat (2) @(posedge i_mclk);
			#1;
			chk("boost mv", 16'h1194 + 16'h32 * codes[k], o_boost_mv);
			chk("pos mv", bias(codes[k]), o_positive_mv);
			chk("neg mv", bias(codes[k]), o_negative_mv);
			chk("ref mv", bias(codes[k]), o_reference_mv);
		end
		host.wr(8'h0b, 8'h11);
		wait_for(0, 1'b1);
		chkd("logic up", 2 * CPM + 2, n);
		host.wr(8'h0b, 8'h04);
		wait_for(0, 1'b0);
		chkd("logic down", 5 * CPM + 2, n);
		host.wr(8'h10, 8'h00);
		@(posedge i_mclk);
		ena[0] <= 1'b1;
		repeat (20) @(posedge i_mclk);
		#1;
		chk("boost idle", 16'h0, o_boost_enable);
		chk("pos held", 16'h0, o_positive_on);
		chk("backlight held", 16'h0, o_backlight_allow);
		host.pin(1'b1);
		wait_for(1, 1'b1);
		chk("boost first", 16'h1, o_boost_enable);
		chk("backlight free", 16'h1, o_backlight_allow);
		@(posedge i_mclk);
		i_reference_enable <= 1'b1;
		@(posedge i_mclk);
		#1;
		chk("ref on", 16'h1, o_reference_on);
		@(posedge i_mclk);
		ena[0] <= 1'b0;
		i_reference_enable <= 1'b0;
		wait_for(1, 1'b0);
		rail(8'h10, 8'h32, 0);
		rail(8'h11, 8'hf1, 1);
		close_out();
	end
endmodule : lbr_regs_tb
